// [rtl/rsp_mode_ctrl.sv]
// Mode, lock and preamble control of the read sync PLL
`default_nettype none
module rsp_mode_ctrl
	import rsp_pkg::*;
#(
	parameter int ZPS_CYC = ZPS_HOLD_CYC
) (
	input  wire logic          i_sys_clk,            // System clock
	input  wire logic          i_sys_rst,            // Async reset, high
	input  wire logic          i_clk_en,             // Freezes state when low
	input  wire logic          i_read_window_gate,   // Read mode, async
	input  wire logic          i_freq_acq_ctrl,      // Freq lock off, async
	input  wire logic          i_vco_band_sel_0,     // Band select bit 0
	input  wire logic          i_vco_band_sel_1,     // Band select bit 1
	input  wire logic          i_vco_band_sel_2,     // Band select bit 2
	input  wire logic          i_preamble_type_sel_0, // Preamble type bit 0
	input  wire logic          i_preamble_type_sel_1, // Preamble type bit 1
	input  wire logic          i_media_pulse_in,     // Read pulses
	input  wire logic          i_ref_freq_in,        // Reference clock
	input  wire logic          i_vco_in,             // VCO clock sample
	input  wire logic          i_cfg_shift_clk,      // Config shift clock
	input  wire logic          i_cfg_serial_in,      // Config serial data
	input  wire logic          i_cfg_load_enable_n,  // Config load, low shifts
	input  wire logic [AW-1:0] i_addr,               // Register address
	input  wire logic [DW-1:0] i_wdata,              // Register write data
	input  wire logic          i_wr,                 // Write strobe
	input  wire logic          i_rd,                 // Read strobe
	output logic      [DW-1:0] o_rdata,              // Read data, next cycle
	output logic               o_irq,                // Level interrupt
	output logic               o_pll_src_data,       // PLL follows media
	output logic               o_zps_active,         // Zero phase start
	output logic               o_vco_restart,        // VCO restart pulse
	output logic               o_freq_lock_en,       // Frequency lock on
	output logic               o_pulse_gate_en,      // Pulse gated compare
	output logic      [2:0]    o_acq_period,         // Lock period in T
	output logic      [2:0]    o_vco_band,           // Applied VCO band
	output logic               o_phase_evt,          // Phase compare edge
	output logic               o_recov_clk,          // Recovered clock
	output logic               o_preamble_found,     // Preamble found
	output logic      [CFG_W-1:0] o_cfg_word         // Applied config
);
	rsp_cfg_if #(.W(CFG_W)) cfg_bus ();

	assign cfg_bus.shift_clk = i_cfg_shift_clk;
	assign cfg_bus.ser_in    = i_cfg_serial_in;
	assign cfg_bus.load_n    = i_cfg_load_enable_n;

	rsp_cfg_shift #(.W(CFG_W)) u_cfg (
		.i_sys_clk (i_sys_clk),
		.i_sys_rst (i_sys_rst),
		.i_clk_en  (i_clk_en),
		.cfg       (cfg_bus)
	);

	// Async control pins, two flops each
	logic            rwg_m_r;
	logic            rwg_s;
	logic            fac_m_r;
	logic            fac_s;
	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			rwg_m_r <= 1'b0;
			rwg_s   <= 1'b0;
			fac_m_r <= 1'b0;
			fac_s   <= 1'b0;
		end else if (i_clk_en) begin
			rwg_m_r <= i_read_window_gate; // see R3
			rwg_s   <= rwg_m_r;
			fac_m_r <= i_freq_acq_ctrl;    // see R12
			fac_s   <= fac_m_r;
		end
	end

	logic            media_prev_r;
	logic            ref_prev_r;
	logic            vco_prev_r;
	wire             media_rise = i_media_pulse_in & ~media_prev_r; // see R8
	wire             ref_rise   = i_ref_freq_in & ~ref_prev_r;
	wire             vco_rise   = i_vco_in & ~vco_prev_r;
	wire       [1:0] pre_type   = {i_preamble_type_sel_1, i_preamble_type_sel_0};
	wire       [2:0] band_in    = {i_vco_band_sel_2, i_vco_band_sel_1, i_vco_band_sel_0};
	wire             band_ok    = band_in <= BAND_MAX;

	// Zero phase start sequencer
	rsp_mode_t        mode_r;
	rsp_mode_t        mode_nxt;
	logic [ZPS_W-1:0] zcnt_r;
	wire              zps_ready = zcnt_r == '0;
	wire              in_zps    = (mode_r == MODE_ZPS_DATA) || (mode_r == MODE_ZPS_REF);
	wire              enter_zps = (mode_nxt != mode_r) &&
		((mode_nxt == MODE_ZPS_DATA) || (mode_nxt == MODE_ZPS_REF));
	wire              zps_done  = in_zps && !enter_zps && (mode_nxt != mode_r);

	// VCO is held during the wait and restarts on the first target edge
	always_comb begin
		mode_nxt = mode_r;
		unique case (mode_r)
			MODE_REF: begin
				if (rwg_s)
					mode_nxt = MODE_ZPS_DATA; // see R1
			end
			MODE_ZPS_DATA: begin
				if (!rwg_s)
					mode_nxt = MODE_ZPS_REF;
				else if (zps_ready && media_rise)
					mode_nxt = MODE_DATA; // see R1
			end
			MODE_DATA: begin
				if (!rwg_s)
					mode_nxt = MODE_ZPS_REF; // see R2
			end
			MODE_ZPS_REF: begin
				if (rwg_s)
					mode_nxt = MODE_ZPS_DATA;
				else if (zps_ready && ref_rise)
					mode_nxt = MODE_REF; // see R2
			end
			default: mode_nxt = MODE_ZPS_REF;
		endcase
	end

	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			mode_r       <= MODE_REF;
			zcnt_r       <= '0;
			media_prev_r <= 1'b1;
			ref_prev_r   <= 1'b1;
			vco_prev_r   <= 1'b1;
		end else if (i_clk_en) begin
			mode_r       <= mode_nxt;
			if (enter_zps)
				zcnt_r <= ZPS_W'(ZPS_CYC);
			else if (!zps_ready)
				zcnt_r <= zcnt_r - 1'b1;
			media_prev_r <= i_media_pulse_in;
			ref_prev_r   <= i_ref_freq_in;
			vco_prev_r   <= i_vco_in;
		end
	end

	// Lock mode outputs
	wire        flock_nxt  = !rwg_s || !fac_s;  // see R9 see R10
	wire        pgate_nxt  = rwg_s && fac_s;    // see R11
	wire [2:0]  period_nxt = {1'b0, pre_type} + 3'h1; // see R14
	wire        phase_nxt  = (mode_r == MODE_DATA) ? media_rise :
		(mode_r == MODE_REF) ? ref_rise : 1'b0;

	// Preamble search counts VCO periods between code bits
	logic [3:0] vcnt_r;
	logic [5:0] pre_cnt_r;
	logic       found_r;
	wire  [3:0] vcnt_eff  = vcnt_r + {3'h0, vco_rise};
	wire        pre_match = media_rise && (vcnt_eff == {1'b0, period_nxt}); // see R15
	wire  [5:0] pre_thr   = (pre_type == PRE_TYPE_4T) ?
		6'(PRE_THR_LONG) : 6'(PRE_THR_SHORT); // see R16
	wire        pre_hit   = pre_cnt_r >= pre_thr;
	wire        found_nxt = rwg_s && (found_r || pre_hit); // see R17
	wire        pre_evt   = found_nxt && !found_r;

	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			vcnt_r    <= '0;
			pre_cnt_r <= '0;
			found_r   <= 1'b0;
		end else if (i_clk_en) begin
			if (media_rise)
				vcnt_r <= '0;
			else if (vco_rise && vcnt_r != 4'hf)
				vcnt_r <= vcnt_r + 1'b1;
			if (mode_r != MODE_DATA)
				pre_cnt_r <= '0;
			else if (media_rise)
				pre_cnt_r <= pre_match ? (pre_hit ? pre_cnt_r : pre_cnt_r + 1'b1) : '0;
			found_r   <= found_nxt;
		end
	end

	// Recovered clock switches only while output and new source are low
	logic clk_sel_r;
	logic clk_r;
	wire  want_vco  = mode_r == MODE_DATA;
	wire  new_src   = want_vco ? i_vco_in : i_ref_freq_in;
	wire  may_sw    = (want_vco != clk_sel_r) && !clk_r && !new_src;
	wire  sel_nxt   = may_sw ? want_vco : clk_sel_r;

	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			clk_sel_r <= 1'b0;
			clk_r     <= 1'b0;
		end else if (i_clk_en) begin
			clk_sel_r <= sel_nxt; // see R18
			clk_r     <= sel_nxt ? i_vco_in : i_ref_freq_in;
		end
	end

	// Registered data outputs
	logic [2:0] band_r;
	logic       flock_r;
	logic       pgate_r;
	logic [2:0] period_r;
	logic       phase_r;
	logic       restart_r;
	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			band_r    <= BAND_RST;
			flock_r   <= 1'b1;
			pgate_r   <= 1'b0;
			period_r  <= 3'h1;
			phase_r   <= 1'b0;
			restart_r <= 1'b0;
		end else if (i_clk_en) begin
			if (band_ok) // see R4
				band_r <= band_in;
			flock_r   <= flock_nxt;
			pgate_r   <= pgate_nxt;
			period_r  <= period_nxt;
			phase_r   <= phase_nxt;
			restart_r <= zps_done;
		end
	end

	// Register port: sticky status, mask, state view, applied config
	logic [STAT_W-1:0] status_r;
	logic [STAT_W-1:0] mask_r;
	logic [DW-1:0]     rdata_r;
	wire  [STAT_W-1:0] ev_set;
	assign ev_set[EV_PRE]  = pre_evt;
	assign ev_set[EV_ZPS]  = zps_done;
	assign ev_set[EV_BAND] = !band_ok;
	assign ev_set[EV_CFG]  = cfg_bus.loaded;
	wire               wr_status = i_wr && (i_addr == REG_STATUS);
	wire               wr_mask   = i_wr && (i_addr == REG_MASK);
	wire  [STAT_W-1:0] clr_bits  = wr_status ? i_wdata[STAT_W-1:0] : '0;
	// Set wins over a clear in the same cycle
	wire  [STAT_W-1:0] status_nxt = (status_r & ~clr_bits) | ev_set;
	wire  [DW-1:0]     state_word =
		{1'b0, band_r, found_r, want_vco, in_zps, rwg_s};
	wire  [DW-1:0]     rd_mux =
		(i_addr == REG_STATUS) ? {{(DW-STAT_W){1'b0}}, status_r} :
		(i_addr == REG_MASK)   ? {{(DW-STAT_W){1'b0}}, mask_r} :
		(i_addr == REG_STATE)  ? state_word :
		(i_addr == REG_CFG)    ? cfg_bus.word : '0;

	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			status_r <= '0;
			mask_r   <= MASK_RST;
			rdata_r  <= '0;
		end else if (i_clk_en) begin
			status_r <= status_nxt;
			if (wr_mask)
				mask_r <= i_wdata[STAT_W-1:0];
			rdata_r  <= i_rd ? rd_mux : '0;
		end
	end

	assign o_rdata          = rdata_r;
	assign o_irq            = |(status_r & mask_r);
	assign o_pll_src_data   = want_vco;
	assign o_zps_active     = in_zps;
	assign o_vco_restart    = restart_r;
	assign o_freq_lock_en   = flock_r;
	assign o_pulse_gate_en  = pgate_r;
	assign o_acq_period     = period_r;
	assign o_vco_band       = band_r;
	assign o_phase_evt      = phase_r;
	assign o_recov_clk      = clk_r;
	assign o_preamble_found = found_r;
	assign o_cfg_word       = cfg_bus.word;

	a_gate_rise_zps: assert property (@(posedge i_sys_clk) // see R1
		disable iff (i_sys_rst || !i_clk_en)
		$rose(rwg_s) |=> mode_r == MODE_ZPS_DATA)
		else $error("gate rise did not start zero phase start");
	a_gate_fall_zps: assert property (@(posedge i_sys_clk) // see R2
		disable iff (i_sys_rst || !i_clk_en)
		$fell(rwg_s) |=> mode_r == MODE_ZPS_REF)
		else $error("gate fall did not start zero phase start");
	a_gate_sync_lat: assert property (@(posedge i_sys_clk) // see R3
		disable iff (i_sys_rst || !i_clk_en)
		$rose(i_read_window_gate) ##1 i_read_window_gate |=> rwg_s)
		else $error("gate synchroniser latency wrong");
	a_band_in_range: assert property (@(posedge i_sys_clk) // see R4
		disable iff (i_sys_rst)
		o_vco_band <= BAND_MAX)
		else $error("illegal VCO band applied");
	a_flock_gate_low: assert property (@(posedge i_sys_clk) // see R9
		disable iff (i_sys_rst || !i_clk_en)
		!rwg_s |=> o_freq_lock_en && !o_pulse_gate_en)
		else $error("frequency lock dropped with gate low");
	a_pgate_read_on: assert property (@(posedge i_sys_clk) // see R11
		disable iff (i_sys_rst || !i_clk_en)
		rwg_s && fac_s |=> o_pulse_gate_en && !o_freq_lock_en)
		else $error("pulse gate not taken over in read");
	a_acq_period_sel: assert property (@(posedge i_sys_clk) // see R14
		disable iff (i_sys_rst || !i_clk_en)
		1'b1 |=> o_acq_period == 3'($past(pre_type)) + 3'h1)
		else $error("acquisition period does not follow type");
	a_found_needs_cnt: assert property (@(posedge i_sys_clk) // see R16
		disable iff (i_sys_rst || !i_clk_en)
		$rose(found_r) |-> $past(pre_cnt_r) >= $past(pre_thr))
		else $error("preamble found before pulse count");
	a_found_cleared: assert property (@(posedge i_sys_clk) // see R17
		disable iff (i_sys_rst || !i_clk_en)
		!rwg_s |=> !o_preamble_found)
		else $error("preamble found high with gate low");
	a_found_latched: assert property (@(posedge i_sys_clk) // see R17
		disable iff (i_sys_rst || !i_clk_en)
		found_r && rwg_s |=> found_r)
		else $error("preamble found dropped during read");
	a_clk_sw_low: assert property (@(posedge i_sys_clk) // see R18
		disable iff (i_sys_rst || !i_clk_en)
		$changed(clk_sel_r) |-> !$past(clk_r) && !clk_r)
		else $error("clock mux switched while high");
endmodule : rsp_mode_ctrl
`default_nettype wire

// [inc/rsp_pkg.sv]
// Constants and types for the read sync PLL mode control block
`default_nettype none
package rsp_pkg;
	// Behaviour
	// R1 - Gate rise starts zero phase start, then lock to media pulses
	// R2 - Gate fall starts zero phase start, then lock to reference input
	// R3 - Read window gate is asynchronous and is synchronised inside
	// R4 - Three band select bits choose one of six VCO bands
	// R5 - Shift clock edges shift serial bits while load enable is low
	// R6 - Load enable rise latches shifted bits and applies them
	// R7 - Serial bit is sampled on the shift clock falling edge
	// R8 - Each media pulse rising edge is one code bit
	// R9 - Gate low forces frequency lock whatever acquisition control says
	// R10 - Read with acquisition control low locks to chosen preamble frequency
	// R11 - Acquisition control high in read ends frequency lock, gates pulses
	// R12 - Acquisition control is asynchronous and is synchronised inside
	// R13 - System may tie acquisition control to preamble found
	// R14 - Preamble type picks the frequency acquired during frequency lock
	// R15 - Preamble type picks the pattern the detector searches for
	// R16 - Preamble found after 32 pulses, or 16 of the 4T pattern
	// R17 - Preamble found stays high until gate falls, low while gate low
	// R18 - Recovered clock is VCO in read lock, else reference, glitch free
	// R19 - Shift stage is separate; applied copy changes only at load
	localparam int          CLK_HZ       = 20_000_000;
	localparam int          ZPS_HOLD_NS  = 200;
	localparam int          ZPS_HOLD_CYC =
		(ZPS_HOLD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int          ZPS_W        = 8;
	localparam int          PRE_THR_SHORT = 32;
	localparam int          PRE_THR_LONG  = 16;
	localparam logic [1:0]  PRE_TYPE_4T  = 2'h3;
	localparam logic [2:0]  BAND_MAX     = 3'h5;
	localparam logic [2:0]  BAND_RST     = 3'h0;
	localparam int          CFG_W        = 8;
	localparam int          DW           = 8;
	localparam int          AW           = 4;
	localparam logic [3:0]  REG_STATUS   = 4'h0;
	localparam logic [3:0]  REG_MASK     = 4'h4;
	localparam logic [3:0]  REG_STATE    = 4'h8;
	localparam logic [3:0]  REG_CFG      = 4'hc;
	localparam int          STAT_W       = 4;
	localparam int          EV_PRE       = 0;
	localparam int          EV_ZPS       = 1;
	localparam int          EV_BAND      = 2;
	localparam int          EV_CFG       = 3;
	localparam logic [3:0]  MASK_RST     = 4'h0;
	typedef enum logic [3:0] {
		MODE_REF      = 4'h1,
		MODE_ZPS_DATA = 4'h2,
		MODE_DATA     = 4'h4,
		MODE_ZPS_REF  = 4'h8
	} rsp_mode_t;
endpackage : rsp_pkg
`default_nettype wire

// [inc/rsp_cfg_if.sv]
// Serial configuration signals between the top and the shift stage
`default_nettype none
interface rsp_cfg_if #(parameter int W = 8);
	logic         shift_clk;
	logic         ser_in;
	logic         load_n;
	logic [W-1:0] word;
	logic         loaded;
	modport ctl (output shift_clk, output ser_in, output load_n,
		input word, input loaded);
	modport shr (input shift_clk, input ser_in, input load_n,
		output word, output loaded);
endinterface : rsp_cfg_if
`default_nettype wire

// [rtl/rsp_cfg_shift.sv]
// Serial configuration shift stage and applied copy
`default_nettype none
module rsp_cfg_shift
	import rsp_pkg::*;
#(
	parameter int W = CFG_W
) (
	input  wire logic i_sys_clk, // System clock
	input  wire logic i_sys_rst, // Async reset, high
	input  wire logic i_clk_en,  // Freezes state when low
	rsp_cfg_if.shr    cfg        // Serial pins and applied word
);
	logic         sclk_prev_r;
	logic         load_prev_r;
	logic [W-1:0] sh_r;
	logic [W-1:0] word_r;
	logic         loaded_r;
	wire          sclk_fall = sclk_prev_r & ~cfg.shift_clk;
	wire          do_shift  = sclk_fall & ~cfg.load_n;
	wire          load_rise = ~load_prev_r & cfg.load_n;

	// Shift clock memory resets low: a pin idling low gives no false fall
	// Load memory resets high: a pin idling high gives no false rise
	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			sclk_prev_r <= 1'b0;
			load_prev_r <= 1'b1;
			sh_r        <= '0;
			word_r      <= '0;
			loaded_r    <= 1'b0;
		end else if (i_clk_en) begin
			sclk_prev_r <= cfg.shift_clk;
			load_prev_r <= cfg.load_n;
			if (do_shift) // see R5 see R7
				sh_r <= {sh_r[W-2:0], cfg.ser_in};
			if (load_rise) // see R6 see R19
				word_r <= sh_r;
			loaded_r    <= load_rise;
		end
	end

	assign cfg.word   = word_r;
	assign cfg.loaded = loaded_r;

	a_cfg_shift_in: assert property (@(posedge i_sys_clk) // see R7
		disable iff (i_sys_rst || !i_clk_en)
		do_shift |=> sh_r == {$past(sh_r[W-2:0]), $past(cfg.ser_in)})
		else $error("shift stage missed a falling edge bit");
	a_cfg_hold_word: assert property (@(posedge i_sys_clk) // see R19
		disable iff (i_sys_rst || !i_clk_en)
		!load_rise |=> $stable(word_r))
		else $error("applied word changed without load");
	a_cfg_load_copy: assert property (@(posedge i_sys_clk) // see R6
		disable iff (i_sys_rst || !i_clk_en)
		load_rise |=> (word_r == $past(sh_r)) && loaded_r)
		else $error("load did not apply shifted bits");
endmodule : rsp_cfg_shift
`default_nettype wire

// [dv/rsp_far_model.sv]
// Far side model: pulse detector stream, VCO sample and reference clock
`default_nettype none
module rsp_far_model (
	input  wire logic       i_sys_clk, // System clock
	input  wire logic       i_sys_rst, // Async reset, high
	input  wire logic       i_run,     // Send preamble pulses
	input  wire logic [2:0] i_period,  // Pulse spacing in VCO periods
	output logic            o_media,   // Pulse detector output
	output logic            o_vco,     // VCO sample, half clock rate
	output logic            o_ref      // Reference, quarter clock rate
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] cnt_r;
	logic [1:0] ref_r;
	// Reference slower than VCO so the recovered clock source is visible
	assign o_ref = ref_r[1];
	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			cnt_r   <= 4'h0;
			ref_r   <= 2'h0;
			o_vco   <= 1'b0;
			o_media <= 1'b0;
		end else begin
			o_vco   <= ~o_vco;
			ref_r   <= ref_r + 2'h1;
			cnt_r   <= (cnt_r >= {i_period, 1'b0} - 4'h1) ? 4'h0 : cnt_r + 4'h1;
			// One cycle pulses: rises carry the bits, line idles low
			o_media <= i_run && (cnt_r == 4'h0);
		end
	end
endmodule : rsp_far_model
`default_nettype wire

// [dv/tb_top.sv]
// Self-checking bench of the read sync PLL mode control block
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
	$display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
`define RCHK(a, e) begin rd_reg(a, rv); `CHK(rv, e) end
`define WAITC(c, n) begin wcnt = 0; while (!(c) && wcnt < n) begin cyc(1); wcnt++; end \
	`CHK(c, 1'b1) if (!(c)) final_report(); end
module tb_top import rsp_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int ZC = 1;
	logic       clk = 1'b0, rst = 1'b1, gate = 1'b0, acq = 1'b0, run = 1'b0;
	logic       sclk = 1'b0, sin = 1'b0, load_n = 1'b1, wr = 1'b0, rd = 1'b0, en = 1'b1;
	logic [2:0] band = 3'h0, period = 3'h1;
	logic [1:0] ptype = 2'h0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00, rv;
	wire logic  media, vco, refc, irq, src_data, zps, restart, flock, pgate, evt, rclk, found;
	wire logic [7:0] rdata, cfg_word;
	wire logic [2:0] acq_per, vband;
	int         errors = 0, cmp_count = 0, wcnt, ne, nr, thr;
	logic [1:0] tt [3] = '{2'h0, 2'h3, 2'h2};
	logic [2:0] pp [3] = '{3'h1, 3'h4, 3'h2};
	logic       ff [3] = '{1'b1, 1'b1, 1'b0};

	always #25 clk = ~clk;

	rsp_far_model far (.i_sys_clk(clk), .i_sys_rst(rst), .i_run(run), .i_period(period),
		.o_media(media), .o_vco(vco), .o_ref(refc));

	rsp_mode_ctrl #(.ZPS_CYC(ZC)) uut (.i_sys_clk(clk), .i_sys_rst(rst), .i_clk_en(en),
		.i_read_window_gate(gate), .i_freq_acq_ctrl(acq), .i_vco_band_sel_0(band[0]),
		.i_vco_band_sel_1(band[1]), .i_vco_band_sel_2(band[2]),
		.i_preamble_type_sel_0(ptype[0]), .i_preamble_type_sel_1(ptype[1]),
		.i_media_pulse_in(media), .i_ref_freq_in(refc), .i_vco_in(vco),
		.i_cfg_shift_clk(sclk), .i_cfg_serial_in(sin), .i_cfg_load_enable_n(load_n),
		.i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
		.o_irq(irq), .o_pll_src_data(src_data), .o_zps_active(zps),
		.o_vco_restart(restart), .o_freq_lock_en(flock), .o_pulse_gate_en(pgate),
		.o_acq_period(acq_per), .o_vco_band(vband), .o_phase_evt(evt),
		.o_recov_clk(rclk), .o_preamble_found(found), .o_cfg_word(cfg_word));

	task automatic final_report;
		if (errors == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : final_report

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc

	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		wr    <= 1'b1;
		addr  <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask : wr_reg

	task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		rd   <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : rd_reg

	// Bit set up on the rising edge as its inverse, so only a falling sample is right
	task automatic cfg_send(input logic [7:0] v, input logic en);
		@(posedge clk);
		load_n <= ~en;
		for (int i = 7; i >= 0; i--) begin
			@(posedge clk);
			sclk <= 1'b1;
			sin  <= ~v[i];
			@(posedge clk);
			sin <= v[i];
			@(posedge clk);
			sclk <= 1'b0;
			@(posedge clk);
			sin <= ~v[i];
		end
	endtask : cfg_send

	// Phase events and recovered clock rises over a 40 cycle window
	task automatic measure;
		logic pr;
		ne = 0;
		nr = 0;
		pr = rclk;
		repeat (40) begin
			cyc(1);
			if (evt === 1'b1) ne++;
			if (rclk === 1'b1 && pr !== 1'b1) nr++;
			pr = rclk;
		end
	endtask : measure

	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		cyc(1);
		`CHK({flock, acq_per, src_data, found, irq, cfg_word}, {1'b1, 3'h1, 11'h000})
		`RCHK(REG_MASK, MASK_RST)
		for (int b = 0; b < 8; b++) begin
			@(posedge clk);
			band <= b[2:0];
			cyc(2);
			`CHK(vband, (b <= 5) ? b[2:0] : BAND_MAX)
		end
		@(posedge clk);
		band <= BAND_MAX;
		`RCHK(REG_STATUS, 8'h04)
		wr_reg(REG_MASK, 8'h04);
		`CHK(irq, 1'b1)
		wr_reg(REG_STATUS, 8'h04);
		`CHK(irq, 1'b0)
		wr_reg(4'h2, 8'hff);
		wr_reg(REG_STATE, 8'hff);
		`RCHK(4'h2, 8'h00)
		`RCHK(REG_MASK, 8'h04)
		`RCHK(REG_STATE, 8'h50)
		for (int t = 0; t < 4; t++) begin
			@(posedge clk);
			ptype <= t[1:0];
			cyc(2);
			`CHK(acq_per, t[2:0] + 3'h1)
		end
		@(posedge clk);
		acq <= 1'b1;
		cyc(4);
		`CHK({flock, pgate}, 2'b10)
		measure();
		`CHK({ne, nr}, {32'd10, 32'd10})
		for (int k = 0; k < 3; k++) begin
			thr = (tt[k] == PRE_TYPE_4T) ? PRE_THR_LONG : PRE_THR_SHORT;
			wr_reg(REG_STATUS, 8'h0f);
			@(posedge clk);
			ptype  <= tt[k];
			period <= pp[k];
			run    <= 1'b1;
			acq    <= 1'b0;
			gate   <= 1'b1;
			`WAITC(zps === 1'b1, 10)
			`CHK({flock, pgate, src_data}, 3'b100)
			`WAITC(src_data === 1'b1, 40)
			`CHK(restart, 1'b1)
			cyc(1);
			`CHK(restart, 1'b0)
			wcnt = 0;
			while (found !== 1'b1 && wcnt < 400) begin
				cyc(1);
				wcnt++;
			end
			`CHK(found, ff[k])
			if (ff[k]) begin
				`CHK(wcnt >= (thr - 2) * 2 * pp[k] && wcnt <= (thr + 2) * 2 * pp[k], 1'b1)
			end
			`RCHK(REG_STATUS, {6'h00, 1'b1, ff[k]})
			measure();
			`CHK({ne, nr}, {20 / int'(pp[k]), 32'd20})
			@(posedge clk);
			acq <= ff[k] ? found : 1'b1;
			cyc(4);
			`CHK({flock, pgate, found}, {2'b01, ff[k]})
			`RCHK(REG_STATE, {1'b0, BAND_MAX, ff[k], 3'b101})
			@(posedge clk);
			gate <= 1'b0;
			`WAITC(zps === 1'b1, 10)
			`CHK(found, 1'b0)
			`WAITC(zps === 1'b0 && src_data === 1'b0, 40)
			`CHK({flock, pgate}, 2'b10)
			@(posedge clk);
			run <= 1'b0;
		end
		cfg_send(8'ha5, 1'b1);
		cyc(3);
		`CHK(cfg_word, 8'h00)
		@(posedge clk);
		load_n <= 1'b1;
		cyc(2);
		`CHK(cfg_word, 8'ha5)
		`RCHK(REG_CFG, 8'ha5)
		`RCHK(REG_STATUS, 8'h0a)
		cfg_send(8'h3c, 1'b0);
		@(posedge clk);
		load_n <= 1'b0;
		@(posedge clk);
		load_n <= 1'b1;
		cyc(3);
		`CHK(cfg_word, 8'ha5)
		@(posedge clk);
		en   <= 1'b0;
		band <= 3'h3;
		cyc(3);
		`CHK(vband, BAND_MAX)
		@(posedge clk);
		en <= 1'b1;
		cyc(2);
		`CHK(vband, 3'h3)
		final_report();
	end
endmodule : tb_top
`default_nettype wire
